//--- bench/pds_chk.sv
// Interface-level assertions of the power-down sequencer link
`timescale 1ns/1ps
module pds_chk #(
  parameter int PARK_CYC  = pds_pkg::PARK_MAX_CYC,
  parameter int DISCH_CYC = pds_pkg::DISCH_MAX_CYC
) (
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  input  wire logic power_request_in,
  input  wire logic mirror_park_n,
  input  wire logic system_reset_n,
  input  wire logic spi_sclk,
  input  wire logic spi_cs_n,
  input  wire logic spi_mosi,
  input  wire logic spi_miso,
  input  wire logic adc_clk,
  input  wire logic adc_din,
  input  wire logic adc_dout
);
  localparam int SEQ_CYC = PARK_CYC + DISCH_CYC;
  localparam int CNT_W   = $clog2(SEQ_CYC + 2);
  logic [CNT_W-1:0] park_cnt_r;
  logic [CNT_W-1:0] park_cnt_nxt;
  logic             parked_live;

  // Cycles spent parked with system reset still released
  assign parked_live  = !mirror_park_n && system_reset_n;
  assign park_cnt_nxt = parked_live ? CNT_W'(park_cnt_r + 1'b1) : '0;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      park_cnt_r <= '0;
    end else begin
      park_cnt_r <= park_cnt_nxt;
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  a_req_park_delay: assert property (
    $fell(power_request_in) && mirror_park_n && system_reset_n |-> ##[1:8] !mirror_park_n)
    else $error("park late after request fall");
  a_reset_timing: assert property (
    $fell(system_reset_n) |-> park_cnt_r == CNT_W'(SEQ_CYC))
    else $error("reset fall not at park plus discharge time");
  a_reset_bound: assert property (
    park_cnt_r <= CNT_W'(SEQ_CYC))
    else $error("reset overdue after park");
  a_reset_order: assert property (
    $fell(system_reset_n) |-> !mirror_park_n)
    else $error("reset asserted without park");
  a_release_pair: assert property (
    $rose(mirror_park_n) |-> $rose(system_reset_n))
    else $error("park released mid sequence");
  a_miso_edge: assert property (
    $changed(spi_miso) |-> !spi_sclk)
    else $error("serial out changed with clock high");
  a_mosi_edge: assert property (
    $changed(spi_mosi) |-> !spi_sclk)
    else $error("serial in changed with clock high");
  a_cs_edge: assert property (
    $changed(spi_cs_n) |-> !spi_sclk)
    else $error("select changed with clock high");
  a_dout_edge: assert property (
    $changed(adc_dout) |-> adc_clk)
    else $error("converter out changed with clock low");
  a_din_edge: assert property (
    $changed(adc_din) |-> !adc_clk)
    else $error("converter in changed with clock high");
endmodule

//--- bench/power_down_sequencer_tb_top.sv
// Self-checking bench joining device and host ends of the link
`timescale 1ns/1ps
module power_down_sequencer_tb_top;
  localparam int TRIP_C  = 40;
  localparam int PARK_C  = 60;
  localparam int DISCH_C = 50;
  localparam int LIMIT   = 20000;
  logic       i_clock, i_sys_rst, i_main_supply_low, i_power_on, i_shutdown;
  logic       i_xfer_start, i_xfer_adc;
  logic [7:0] i_xfer_byte;
  logic       rail_en, dis_bias, dis_off, dis_rst, seq_busy, cmd_v, adc_v;
  logic       xfer_busy, xfer_done, host_park_n, host_reset_n, sclk_q;
  logic [7:0] spi_cmd, adc_word, xfer_rx, got_cmd, got_adc, adc_prev;
  int         n_errors, num_checks, n_cmd, n_adc, n_sclk, cyc;
  int         seed = 54;
  int         n;

  pds_link_if pds_link_if_inst ();
  pds_device #(.TRIP_CYC(TRIP_C), .PARK_CYC(PARK_C), .DISCH_CYC(DISCH_C)) pds_device_inst (
    .link(pds_link_if_inst), .i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_main_supply_low(i_main_supply_low), .o_rail_enable(rail_en),
    .o_bias_discharge(dis_bias), .o_offset_discharge(dis_off), .o_reset_discharge(dis_rst),
    .o_seq_busy(seq_busy), .o_spi_cmd(spi_cmd), .o_spi_cmd_valid(cmd_v),
    .o_adc_word(adc_word), .o_adc_valid(adc_v));
  pds_host pds_host_inst (
    .link(pds_link_if_inst), .i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_power_on(i_power_on), .i_shutdown(i_shutdown), .i_xfer_start(i_xfer_start),
    .i_xfer_adc(i_xfer_adc), .i_xfer_byte(i_xfer_byte), .o_xfer_busy(xfer_busy),
    .o_xfer_rx(xfer_rx), .o_xfer_done(xfer_done), .o_mirror_park_n(host_park_n),
    .o_system_reset_n(host_reset_n));
  pds_chk #(.PARK_CYC(PARK_C), .DISCH_CYC(DISCH_C)) pds_chk_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .power_request_in(pds_link_if_inst.power_request_in),
    .mirror_park_n(pds_link_if_inst.mirror_park_n),
    .system_reset_n(pds_link_if_inst.system_reset_n),
    .spi_sclk(pds_link_if_inst.spi_sclk), .spi_cs_n(pds_link_if_inst.spi_cs_n),
    .spi_mosi(pds_link_if_inst.spi_mosi), .spi_miso(pds_link_if_inst.spi_miso),
    .adc_clk(pds_link_if_inst.adc_clk), .adc_din(pds_link_if_inst.adc_din),
    .adc_dout(pds_link_if_inst.adc_dout));

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // Pulse capture, sequencer clock edge count and hang guard
  always @(posedge i_clock) begin
    sclk_q <= pds_link_if_inst.sequencer_clock;
    if (pds_link_if_inst.sequencer_clock === 1'b1 && sclk_q === 1'b0) n_sclk <= n_sclk + 1;
    if (cmd_v === 1'b1) begin
      got_cmd <= spi_cmd;
      n_cmd <= n_cmd + 1;
    end
    if (adc_v === 1'b1) begin
      got_adc <= adc_word;
      n_adc <= n_adc + 1;
    end
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask

  function automatic logic [7:0] status_of(input logic [2:0] st, input logic [3:0] pins);
    return {st, pins, 1'b0};
  endfunction

  // Waits for a quiet running state, eight cycles in a row
  task automatic wait_run();
    int n;
    int q;
    n = 0;
    q = 0;
    while (q < 8 && n < 400) begin
      tick();
      n++;
      q = (host_park_n === 1'b1 && host_reset_n === 1'b1 && seq_busy === 1'b0) ? q + 1 : 0;
    end
    check(q, 8, "return to run");
  endtask

  task automatic xfer(input logic adc, input logic [7:0] b, output logic [7:0] rx);
    int n;
    n = 0;
    i_xfer_start = 1'b1;
    i_xfer_adc = adc;
    i_xfer_byte = b;
    tick();
    i_xfer_start = 1'b0;
    check(xfer_busy, 1'b1, "busy after start");
    while (xfer_done !== 1'b1 && n < 500) begin
      tick();
      n++;
    end
    check(n < 500, 1, "transfer hang");
    check(xfer_busy, 1'b0, "busy after done");
    rx = xfer_rx;
  endtask

  task automatic spi_round(input logic [7:0] b, input logic [7:0] status);
    logic [7:0] rx;
    int c0;
    c0 = n_cmd;
    xfer(1'b0, b, rx);
    check(rx, status, "status byte");
    check(n_cmd, c0 + 1, "cmd count");
    check(got_cmd, b, "cmd byte");
  endtask

  task automatic adc_round(input logic [7:0] b);
    logic [7:0] rx;
    int c0;
    c0 = n_adc;
    xfer(1'b1, b, rx);
    check(rx, adc_prev, "adc echo");
    check(n_adc, c0 + 1, "adc count");
    check(got_adc, b, "adc word");
    adc_prev = b;
  endtask

  task automatic run_down(input logic by_trip);
    int n;
    if (by_trip) i_main_supply_low = 1'b1;
    else i_shutdown = 1'b1;
    tick();
    i_shutdown = 1'b0;
    n = 1;
    while (pds_link_if_inst.mirror_park_n !== 1'b0 && n < 300) begin
      tick();
      n++;
    end
    if (by_trip) begin
      check(n >= TRIP_C, 1, "trip too early");
      check(n <= TRIP_C * 120 / 52, 1, "trip too late");
    end else begin
      check(n <= 8, 1, "request too late");
    end
    check({seq_busy, rail_en}, 2'b11, "parked state");
    // Trigger removed mid-sequence
    i_main_supply_low = 1'b0;
    n = 0;
    while (dis_off !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    check(n, PARK_C, "park time");
    check({dis_bias, dis_rst, rail_en, pds_link_if_inst.mirror_park_n}, 4'hC, "disch");
    n = 0;
    while (dis_off !== 1'b0 && n < 300) begin
      tick();
      n++;
    end
    check(n, DISCH_C, "discharge time");
    check({pds_link_if_inst.system_reset_n, seq_busy, dis_bias, dis_rst}, 4'h0, "off");
    check(pds_link_if_inst.mirror_park_n, 1'b0, "park held");
  endtask

  initial begin
    n_errors = 0;
    num_checks = 0;
    n_cmd = 0;
    n_adc = 0;
    n_sclk = 0;
    cyc = 0;
    adc_prev = 8'h00;
    {i_main_supply_low, i_power_on, i_shutdown, i_xfer_start, i_xfer_adc} = 5'h00;
    i_xfer_byte = 8'h00;
    i_sys_rst = 1'b1;
    repeat (10) tick();
    i_sys_rst = 1'b0;
    i_power_on = 1'b1;
    tick();
    i_power_on = 1'b0;
    repeat (3) tick();
    check({seq_busy, pds_link_if_inst.mirror_park_n}, 2'b01, "false request edge");
    wait_run();
    for (int i = 0; i < 4; i++) begin
      spi_round(8'($random(seed)), status_of(3'h0, 4'hD));
      adc_round(8'($random(seed)));
    end
    n = n_sclk;
    repeat (1000) tick();
    check((n_sclk - n) >= 146 && (n_sclk - n) <= 151, 1, "sequencer clock");
    run_down(1'b1);
    wait_run();
    run_down(1'b0);
    spi_round(8'hA5, status_of(3'h4, 4'h0));
    i_power_on = 1'b1;
    tick();
    i_power_on = 1'b0;
    wait_run();
    spi_round(8'h00, status_of(3'h0, 4'hD));
    adc_round(8'hFF);
    conclude();
  end
endmodule

//--- hw/pds_device.sv
// Power-down sequencer device end with SPI and ADC serial ports
`timescale 1ns/1ps
module pds_device #(
  parameter int TRIP_CYC  = pds_pkg::TRIP_MIN_CYC,
  parameter int PARK_CYC  = pds_pkg::PARK_MAX_CYC,
  parameter int DISCH_CYC = pds_pkg::DISCH_MAX_CYC,
  parameter int WAIT_W    = pds_pkg::WAIT_WIDTH,
  parameter int BITS      = pds_pkg::XFER_BITS
) (
  pds_link_if.device        link,
  input  wire logic         i_clock,
  input  wire logic         i_sys_rst,
  input  wire logic         i_main_supply_low,
  output logic              o_rail_enable,
  output logic              o_bias_discharge,
  output logic              o_offset_discharge,
  output logic              o_reset_discharge,
  output logic              o_seq_busy,
  output logic [BITS-1:0]   o_spi_cmd,
  output logic              o_spi_cmd_valid,
  output logic [BITS-1:0]   o_adc_word,
  output logic              o_adc_valid
);
  localparam int CNT_W = $clog2(BITS);

  function automatic logic wait_hit(input logic [WAIT_W-1:0] cnt, input int lim);
    return cnt == WAIT_W'(lim - 1);
  endfunction

  function automatic logic bit_last(input logic [CNT_W-1:0] cnt);
    return cnt == CNT_W'(BITS - 1);
  endfunction

  logic main_low;
  logic req_lvl;
  logic req_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_n_lvl;
  logic cs_fall;
  logic mosi_lvl;
  logic aclk_rise;
  logic adin_lvl;

  pds_sync #(.RST_VAL(1'b0)) u_sync_main (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(i_main_supply_low),
    .o_level(main_low), .o_rise(), .o_fall()
  );
  // Reset level matches the host's idle request, so release makes no false fall
  pds_sync #(.RST_VAL(pds_pkg::RST_REQUEST)) u_sync_req (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(link.power_request_in),
    .o_level(req_lvl), .o_rise(), .o_fall(req_fall)
  );
  pds_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(link.spi_sclk),
    .o_level(), .o_rise(sclk_rise), .o_fall(sclk_fall)
  );
  pds_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(link.spi_cs_n),
    .o_level(cs_n_lvl), .o_rise(), .o_fall(cs_fall)
  );
  pds_sync #(.RST_VAL(1'b0)) u_sync_mosi (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(link.spi_mosi),
    .o_level(mosi_lvl), .o_rise(), .o_fall()
  );
  pds_sync #(.RST_VAL(1'b0)) u_sync_aclk (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(link.adc_clk),
    .o_level(), .o_rise(aclk_rise), .o_fall()
  );
  pds_sync #(.RST_VAL(1'b0)) u_sync_adin (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(link.adc_din),
    .o_level(adin_lvl), .o_rise(), .o_fall()
  );

  // Sequencer
  pds_pkg::pds_seq_type state_r;
  pds_pkg::pds_seq_type state_nxt;
  logic [WAIT_W-1:0]    wait_r;
  logic [WAIT_W-1:0]    wait_nxt;
  logic                 park_n_r;
  logic                 reset_n_r;
  logic                 rail_en_r;
  logic                 disch_r;
  logic                 busy_r;
  logic                 parked_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pds_pkg::SEQ_RUN: begin
        if (main_low) begin
          state_nxt = pds_pkg::SEQ_TRIP_WAIT;
        end else if (req_fall) begin
          state_nxt = pds_pkg::SEQ_PARK;
        end
      end
      pds_pkg::SEQ_TRIP_WAIT: begin
        if (wait_hit(wait_r, TRIP_CYC)) begin
          state_nxt = pds_pkg::SEQ_PARK;
        end
      end
      pds_pkg::SEQ_PARK: begin
        if (wait_hit(wait_r, PARK_CYC)) begin
          state_nxt = pds_pkg::SEQ_DISCHARGE;
        end
      end
      pds_pkg::SEQ_DISCHARGE: begin
        if (wait_hit(wait_r, DISCH_CYC)) begin
          state_nxt = pds_pkg::SEQ_OFF;
        end
      end
      pds_pkg::SEQ_OFF: begin
        if (req_lvl && !main_low) begin
          state_nxt = pds_pkg::SEQ_RUN;
        end
      end
      default: begin
        state_nxt = pds_pkg::SEQ_RUN;
      end
    endcase
  end

  // Timer restarts on every state change
  assign wait_nxt   = (state_nxt != state_r) ? '0 : WAIT_W'(wait_r + 1'b1);
  assign parked_nxt = (state_nxt == pds_pkg::SEQ_PARK) ||
                      (state_nxt == pds_pkg::SEQ_DISCHARGE) ||
                      (state_nxt == pds_pkg::SEQ_OFF);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_r   <= pds_pkg::SEQ_RUN;
      wait_r    <= '0;
      park_n_r  <= pds_pkg::RST_PARK_N;
      reset_n_r <= pds_pkg::RST_RESET_N;
      rail_en_r <= 1'b1;
      disch_r   <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      wait_r    <= wait_nxt;
      park_n_r  <= ~parked_nxt;
      reset_n_r <= (state_nxt != pds_pkg::SEQ_OFF);
      rail_en_r <= ~parked_nxt || (state_nxt == pds_pkg::SEQ_PARK);
      disch_r   <= (state_nxt == pds_pkg::SEQ_DISCHARGE);
      busy_r    <= (state_nxt != pds_pkg::SEQ_RUN) && (state_nxt != pds_pkg::SEQ_OFF);
    end
  end

  // Host SPI slave
  logic [BITS-1:0]  status_byte;
  logic [BITS-1:0]  stx_r;
  logic [BITS-1:0]  srx_r;
  logic [BITS-1:0]  srx_nxt;
  logic [CNT_W-1:0] scnt_r;
  logic [BITS-1:0]  cmd_r;
  logic             cmd_vld_r;
  logic             miso_r;

  assign status_byte = BITS'({state_r, park_n_r, reset_n_r, main_low, req_lvl, 1'b0});
  assign srx_nxt     = {srx_r[BITS-2:0], mosi_lvl};

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      stx_r     <= '0;
      srx_r     <= '0;
      scnt_r    <= '0;
      cmd_r     <= '0;
      cmd_vld_r <= 1'b0;
      miso_r    <= 1'b0;
    end else begin
      cmd_vld_r <= 1'b0;
      if (cs_fall) begin
        stx_r  <= status_byte;
        miso_r <= status_byte[BITS-1];
        scnt_r <= '0;
      end else if (cs_n_lvl) begin
        miso_r <= 1'b0;
      end else if (sclk_rise) begin
        srx_r  <= srx_nxt;
        scnt_r <= CNT_W'(scnt_r + 1'b1);
        if (bit_last(scnt_r)) begin
          cmd_r     <= srx_nxt;
          cmd_vld_r <= 1'b1;
          scnt_r    <= '0;
        end
      end else if (sclk_fall) begin
        stx_r  <= {stx_r[BITS-2:0], 1'b0};
        miso_r <= stx_r[BITS-2];
      end
    end
  end

  // ADC serial port: received word is echoed in the next transfer
  logic [BITS-1:0]  atx_r;
  logic [BITS-1:0]  arx_r;
  logic [BITS-1:0]  arx_nxt;
  logic [CNT_W-1:0] acnt_r;
  logic [BITS-1:0]  aword_r;
  logic             avld_r;
  logic             adout_r;

  assign arx_nxt = {arx_r[BITS-2:0], adin_lvl};

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      atx_r   <= '0;
      arx_r   <= '0;
      acnt_r  <= '0;
      aword_r <= '0;
      avld_r  <= 1'b0;
      adout_r <= 1'b0;
    end else begin
      avld_r <= 1'b0;
      if (aclk_rise) begin
        arx_r <= arx_nxt;
        if (bit_last(acnt_r)) begin
          acnt_r  <= '0;
          aword_r <= arx_nxt;
          avld_r  <= 1'b1;
          atx_r   <= arx_nxt;
          adout_r <= arx_nxt[BITS-1];
        end else begin
          acnt_r  <= CNT_W'(acnt_r + 1'b1);
          atx_r   <= {atx_r[BITS-2:0], 1'b0};
          adout_r <= atx_r[BITS-2];
        end
      end
    end
  end

  assign link.mirror_park_n  = park_n_r;
  assign link.system_reset_n = reset_n_r;
  assign link.spi_miso       = miso_r;
  assign link.adc_dout       = adout_r;

  assign o_rail_enable      = rail_en_r;
  assign o_bias_discharge   = disch_r;
  assign o_offset_discharge = disch_r;
  assign o_reset_discharge  = disch_r;
  assign o_seq_busy         = busy_r;
  assign o_spi_cmd          = cmd_r;
  assign o_spi_cmd_valid    = cmd_vld_r;
  assign o_adc_word         = aword_r;
  assign o_adc_valid        = avld_r;
endmodule

//--- hw/pds_host.sv
// Host controller end: power request, sequencer clock, serial master
`timescale 1ns/1ps
module pds_host #(
  parameter int BITS = pds_pkg::XFER_BITS,
  parameter int HALF = pds_pkg::SPI_HALF_CYC
) (
  pds_link_if.host          link,
  input  wire logic         i_clock,
  input  wire logic         i_sys_rst,
  input  wire logic         i_power_on,
  input  wire logic         i_shutdown,
  input  wire logic         i_xfer_start,
  input  wire logic         i_xfer_adc,
  input  wire logic [BITS-1:0] i_xfer_byte,
  output logic              o_xfer_busy,
  output logic [BITS-1:0]   o_xfer_rx,
  output logic              o_xfer_done,
  output logic              o_mirror_park_n,
  output logic              o_system_reset_n
);
  localparam int CNT_W = $clog2(BITS);
  localparam int HLF_W = $clog2(HALF);
  localparam int ACC_W = pds_pkg::SEQ_ACC_WIDTH;

  logic miso_lvl;
  logic adout_lvl;

  pds_sync #(.RST_VAL(1'b0)) u_sync_miso (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(link.spi_miso),
    .o_level(miso_lvl), .o_rise(), .o_fall()
  );
  pds_sync #(.RST_VAL(1'b0)) u_sync_adout (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(link.adc_dout),
    .o_level(adout_lvl), .o_rise(), .o_fall()
  );
  pds_sync #(.RST_VAL(1'b1)) u_sync_park (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(link.mirror_park_n),
    .o_level(o_mirror_park_n), .o_rise(), .o_fall()
  );
  pds_sync #(.RST_VAL(1'b1)) u_sync_rst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(link.system_reset_n),
    .o_level(o_system_reset_n), .o_rise(), .o_fall()
  );

  // Power request, shutdown wins
  logic req_r;
  // Phase accumulator for the 30 MHz sequencer clock
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_sum;
  logic             acc_wrap;
  logic             sequencer_clock_r;

  assign acc_sum  = ACC_W'(acc_r + ACC_W'(pds_pkg::SEQ_ACC_STEP));
  assign acc_wrap = acc_sum >= ACC_W'(pds_pkg::CLOCK_KHZ);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      req_r     <= pds_pkg::RST_REQUEST;
      acc_r     <= '0;
      sequencer_clock_r <= 1'b0;
    end else begin
      if (i_shutdown) begin
        req_r <= 1'b0;
      end else if (i_power_on) begin
        req_r <= 1'b1;
      end
      acc_r <= acc_wrap ? ACC_W'(acc_sum - ACC_W'(pds_pkg::CLOCK_KHZ)) : acc_sum;
      if (acc_wrap) begin
        sequencer_clock_r <= ~sequencer_clock_r;
      end
    end
  end

  // Serial master shared by SPI and ADC links
  pds_pkg::pds_hst_type hst_r;
  logic [HLF_W-1:0] half_r;
  logic [CNT_W-1:0] bit_r;
  logic [BITS-1:0]  tx_r;
  logic [BITS-1:0]  rx_r;
  logic             clk_r;
  logic             sel_r;
  logic             cs_n_r;
  logic             sclk_r;
  logic             aclk_r;
  logic             data_r;
  logic             busy_r;
  logic             done_r;
  logic [BITS-1:0]  rx_out_r;
  logic             half_last;
  logic             in_bit;

  assign half_last = half_r == HLF_W'(HALF - 1);
  assign in_bit    = sel_r ? adout_lvl : miso_lvl;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      hst_r    <= pds_pkg::HST_IDLE;
      half_r   <= '0;
      bit_r    <= '0;
      tx_r     <= '0;
      rx_r     <= '0;
      clk_r    <= 1'b0;
      sel_r    <= 1'b0;
      cs_n_r   <= 1'b1;
      sclk_r   <= 1'b0;
      aclk_r   <= 1'b0;
      data_r   <= 1'b0;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      rx_out_r <= '0;
    end else begin
      done_r <= 1'b0;
      half_r <= HLF_W'(half_r + 1'b1);
      case (hst_r)
        pds_pkg::HST_IDLE: begin
          half_r <= '0;
          if (i_xfer_start) begin
            hst_r  <= pds_pkg::HST_SHIFT;
            sel_r  <= i_xfer_adc;
            tx_r   <= i_xfer_byte;
            data_r <= i_xfer_byte[BITS-1];
            cs_n_r <= i_xfer_adc;
            bit_r  <= '0;
            busy_r <= 1'b1;
          end
        end
        pds_pkg::HST_SHIFT: begin
          if (half_last) begin
            clk_r  <= ~clk_r;
            sclk_r <= ~sel_r & ~clk_r;
            aclk_r <= sel_r & ~clk_r;
            if (!clk_r) begin
              rx_r <= {rx_r[BITS-2:0], in_bit};
            end else begin
              tx_r   <= {tx_r[BITS-2:0], 1'b0};
              data_r <= tx_r[BITS-2];
              if (bit_r == CNT_W'(BITS - 1)) begin
                hst_r <= pds_pkg::HST_END;
              end else begin
                bit_r <= CNT_W'(bit_r + 1'b1);
              end
            end
          end
        end
        pds_pkg::HST_END: begin
          if (half_last) begin
            cs_n_r   <= 1'b1;
            busy_r   <= 1'b0;
            done_r   <= 1'b1;
            rx_out_r <= rx_r;
            hst_r    <= pds_pkg::HST_IDLE;
          end
        end
        default: begin
          hst_r <= pds_pkg::HST_IDLE;
        end
      endcase
    end
  end

  assign link.power_request_in = req_r;
  assign link.sequencer_clock  = sequencer_clock_r;
  assign link.spi_sclk         = sclk_r;
  assign link.spi_cs_n         = cs_n_r;
  assign link.spi_mosi         = data_r;
  assign link.adc_clk          = aclk_r;
  assign link.adc_din          = data_r;
  assign o_xfer_busy           = busy_r;
  assign o_xfer_rx             = rx_out_r;
  assign o_xfer_done           = done_r;
endmodule

//--- hw/pds_sync.sv
// Two-flop pin synchroniser with edge detection on the settled level
`timescale 1ns/1ps
module pds_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  logic meta_r;
  logic level_r;
  logic prev_r;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      meta_r  <= RST_VAL;
      level_r <= RST_VAL;
      prev_r  <= RST_VAL;
    end else begin
      meta_r  <= i_async;
      level_r <= meta_r;
      prev_r  <= level_r;
    end
  end

  assign o_level = level_r;
  assign o_rise  = level_r & ~prev_r;
  assign o_fall  = ~level_r & prev_r;
endmodule

//--- pkg/pds_link_if.sv
// Pin bundle between sequencer device and host controller
`timescale 1ns/1ps
interface pds_link_if;
  logic power_request_in;
  logic sequencer_clock;
  logic mirror_park_n;
  logic system_reset_n;
  logic spi_sclk;
  logic spi_cs_n;
  logic spi_mosi;
  logic spi_miso;
  logic adc_clk;
  logic adc_din;
  logic adc_dout;

  modport device (
    input  power_request_in,
    input  sequencer_clock,
    input  spi_sclk,
    input  spi_cs_n,
    input  spi_mosi,
    input  adc_clk,
    input  adc_din,
    output mirror_park_n,
    output system_reset_n,
    output spi_miso,
    output adc_dout
  );

  modport host (
    output power_request_in,
    output sequencer_clock,
    output spi_sclk,
    output spi_cs_n,
    output spi_mosi,
    output adc_clk,
    output adc_din,
    input  mirror_park_n,
    input  system_reset_n,
    input  spi_miso,
    input  adc_dout
  );
endinterface

//--- pkg/pds_pkg.sv
// Shared constants and types of the power-down sequencer link
package pds_pkg;
  localparam int CLOCK_MHZ      = 200;
  localparam int CLOCK_KHZ      = 200000;
  localparam int T_TRIP_MIN_US  = 52;
  localparam int T_TRIP_MAX_US  = 120;
  localparam int T_REQ_MAX_US   = 1000;
  localparam int T_PARK_MAX_US  = 280;
  localparam int T_DISCH_MAX_US = 260;
  localparam int T_RESET_MAX_US = 500;
  // Least time: exact product, already whole cycles
  localparam int TRIP_MIN_CYC   = T_TRIP_MIN_US * CLOCK_MHZ;
  // Longest times: exact products, no rounding needed
  localparam int PARK_MAX_CYC   = T_PARK_MAX_US * CLOCK_MHZ;
  localparam int DISCH_MAX_CYC  = T_DISCH_MAX_US * CLOCK_MHZ;
  localparam int WAIT_WIDTH     = 17;
  localparam int XFER_BITS      = 8;
  localparam int SPI_HALF_CYC   = 8;
  localparam int SEQUENCER_CLOCK_KHZ    = 30000;
  localparam int SEQ_ACC_STEP   = 2 * SEQUENCER_CLOCK_KHZ;
  localparam int SEQ_ACC_WIDTH  = 18;
  localparam logic RST_PARK_N   = 1'b1;
  localparam logic RST_RESET_N  = 1'b1;
  localparam logic RST_REQUEST  = 1'b0;

  typedef enum logic [2:0] {
    SEQ_RUN,
    SEQ_TRIP_WAIT,
    SEQ_PARK,
    SEQ_DISCHARGE,
    SEQ_OFF
  } pds_seq_type;

  typedef enum logic [1:0] {
    HST_IDLE,
    HST_SHIFT,
    HST_END
  } pds_hst_type;
endpackage
